// ### bench/rhif_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module rhif_host_model (
  output logic      sclk_o,
  output logic      ss_n_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic rd_ind_i
);
  int half = 40;

  // Link clock stands low between frames; only the host opens one
  initial begin
    sclk_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic start();
    #3;
    ss_n_o = 1'b0;
    #half;
  endtask

  // MSB first out on rising edge, in from the falling edge before
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      output logic ind);
    for (int i = 7; i >= 0; i--) begin
      sclk_o = 1'b1;
      mosi_o = tx[i];
      #half;
      sclk_o = 1'b0;
      #half;
      rx[i] = miso_i;
      if (i == 7)
        ind = rd_ind_i;
    end
  endtask

  // Released data line shows the inverse, not a held value
  task automatic stop();
    #half;
    ss_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #(4 * half);
  endtask
endmodule

`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic       mclk_i, nrst_i, rx_active_i, rx_valid_i;
  logic [2:0] strap_i;
  logic [7:0] rx_data_i, tx_data_o;
  logic [4:0] cmd_code_o;
  logic       miso_o, rd_ind_o, irq_o, tx_strobe_o, tx_eof_o, cmd_strobe_o;
  wire logic  sclk, ss_n, mosi;
  int         n_errors, compares, n_tx, eof_at, n_cmd;
  logic [7:0] txq [8];
  logic [7:0] rw [3];
  logic       ri [3];

  rhif_host_if uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .sclk_i(sclk),
    .ss_n_i(ss_n), .mosi_i(mosi), .strap_i(strap_i),
    .rx_active_i(rx_active_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .miso_o(miso_o), .rd_ind_o(rd_ind_o),
    .irq_o(irq_o), .tx_data_o(tx_data_o), .tx_strobe_o(tx_strobe_o),
    .tx_eof_o(tx_eof_o), .cmd_code_o(cmd_code_o),
    .cmd_strobe_o(cmd_strobe_o));

  rhif_host_model host (.sclk_o(sclk), .ss_n_o(ss_n), .mosi_o(mosi),
    .miso_i(miso_o), .rd_ind_i(rd_ind_o));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    if (tx_strobe_o) begin
      txq[n_tx[2:0]] = tx_data_o;
      if (tx_eof_o)
        eof_at = n_tx;
      n_tx++;
    end
    if (cmd_strobe_o)
      n_cmd++;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic frame(input int n, input logic [7:0] a,
                       b = 8'h00, c = 8'h00);
    logic [7:0] w [3];
    w = '{a, b, c};
    host.start();
    for (int k = 0; k < n; k++)
      host.xfer(w[k], rw[k], ri[k]);
    host.stop();
  endtask

  task automatic do_reset(input logic [2:0] s);
    @(negedge mclk_i);
    nrst_i = 1'b0;
    strap_i = s;
    repeat (4) @(negedge mclk_i);
    nrst_i = 1'b1;
    repeat (8) @(negedge mclk_i);
  endtask

  task automatic t_regs();
    frame(3, 8'h3d, 8'h12, 8'h34);
    frame(2, 8'h5d);
    chk("len_high", rw[1], 8'h12);
    chk("ind_addr", ri[0], 1'b0);
    chk("ind_data", ri[1], 1'b1);
    frame(3, 8'h7d);
    chk("cont0", rw[1], 8'h12);
    chk("cont1", rw[2], 8'h34);
    chk("ind_cont", ri[2], 1'b1);
    chk("ind_end", rd_ind_o, 1'b0);
    frame(3, 8'h1e, 8'h56, 8'h78);
    frame(2, 8'h5e);
    chk("single", rw[1], 8'h56);
    frame(2, 8'h10, 8'hff);
    frame(2, 8'h50);
    chk("unmapped", rw[1], 8'h00);
    $display("t_regs done");
  endtask

  // Command words keep bits 6 and 5 clear
  task automatic t_cmd();
    int c0;
    for (int k = 0; k < 32; k++) begin
      c0 = n_cmd;
      frame(1, 8'h80 | 8'(k));
      chk("cmd_code", cmd_code_o, 8'(k));
      chk("cmd_pulse", 8'(n_cmd - c0), 8'h01);
    end
    $display("t_cmd done");
  endtask

  // Length and 128 FIFO bytes in one continuous stream
  task automatic t_fifo();
    logic [7:0] r;
    logic       i;
    frame(1, 8'h8f);
    host.start();
    host.xfer(8'h3d, r, i);
    host.xfer(8'h00, r, i);
    host.xfer(8'h00, r, i);
    for (int k = 0; k < 128; k++)
      host.xfer(8'(k), r, i);
    host.stop();
    frame(2, 8'h5c);
    chk("full", rw[1], 8'hff);
    frame(2, 8'h1c, 8'h00);
    frame(2, 8'h5c);
    chk("ro_status", rw[1], 8'hff);
    frame(2, 8'h5f);
    chk("first", rw[1], 8'h00);
    frame(2, 8'h5f);
    chk("second", rw[1], 8'h01);
    frame(2, 8'h5c);
    chk("sticky", rw[1], 8'hfd);
    frame(1, 8'h8f);
    frame(2, 8'h5c);
    chk("cleared", rw[1], 8'h00);
    $display("t_fifo done");
  endtask

  // Two whole bytes plus a partial one; host writes exactly that many
  task automatic t_tx();
    int t;
    frame(1, 8'h8f);
    chk("irq_idle", irq_o, 1'b0);
    n_tx = 0;
    eof_at = -1;
    frame(3, 8'h3d, 8'h00, 8'h21);
    chk("no_start", 8'(n_tx), 8'h00);
    frame(2, 8'h1f, 8'ha1);
    chk("started", 8'(n_tx), 8'h01);
    chk("irq_tx", irq_o, 1'b1);
    frame(2, 8'h1f, 8'hb2);
    frame(2, 8'h1f, 8'hc3);
    t = 0;
    while (n_tx < 3 && t < 2000) begin
      @(negedge mclk_i);
      t++;
    end
    if (n_tx < 3) begin
      n_errors++;
      summarize();
    end else begin
      chk("tx0", txq[0], 8'ha1);
      chk("tx1", txq[1], 8'hb2);
      chk("tx2", txq[2], 8'hc3);
      chk("eof", 8'(eof_at), 8'h02);
    end
    $display("t_tx done");
  endtask

  task automatic t_rx();
    frame(1, 8'h8f);
    @(negedge mclk_i);
    rx_active_i = 1'b1;
    for (int k = 0; k < 97; k++) begin
      @(negedge mclk_i);
      if (k == 96)
        chk("irq_96", irq_o, 1'b0);
      rx_valid_i = 1'b1;
      rx_data_i = 8'(k);
      @(negedge mclk_i);
      rx_valid_i = 1'b0;
    end
    repeat (2) @(negedge mclk_i);
    chk("irq_97", irq_o, 1'b1);
    rx_active_i = 1'b0;
    frame(2, 8'h5c);
    chk("rx_count", rw[1], 8'h61);
    $display("t_rx done");
  endtask

  task automatic t_straps();
    do_reset(3'h0);
    frame(2, 8'h1d, 8'h5a);
    frame(2, 8'h5d);
    chk("par_none", rw[1], 8'h00);
    do_reset(rhif_pkg::STRAP_SPI_NOSS);
    frame(2, 8'h1d, 8'h5a);
    frame(2, 8'h5d);
    chk("noss_reg", rw[1], 8'h5a);
    frame(2, 8'h1f, 8'h77);
    frame(2, 8'h5c);
    chk("noss_cnt", rw[1], 8'h00);
    frame(2, 8'h5f);
    chk("noss_fifo", rw[1], 8'h00);
    $display("t_straps done");
  endtask

  initial begin
    #1ms;
    n_errors++;
    summarize();
  end

  initial begin
    nrst_i = 1'b0;
    rx_active_i = 1'b0;
    rx_valid_i = 1'b0;
    rx_data_i = 8'h00;
    strap_i = rhif_pkg::STRAP_SPI_SS;
    do_reset(rhif_pkg::STRAP_SPI_SS);
    t_regs();
    t_cmd();
    t_fifo();
    t_tx();
    t_rx();
    t_straps();
    summarize();
  end
endmodule

`default_nettype wire

// ### hdl/rhif_host_if.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Straps after reset pick the serial variant
// - Device is slave; host starts every transfer
// - Interrupt output asks host for service
// - First word after start is control word
// - Control bit 7 set means command
// - Bit 6: zero writes, one reads
// - Continuous bit increments address per word until it reaches the FIFO at 0x1f
// - Command word carries code in bits 4..0
// - Without continuous bit, one data word only
// - Command word triggers the reader action
// - 127-byte cyclic FIFO at address 0x1f
// - Command 0x0f empties FIFO and count
// - FIFO byte count in status bits 6..0
// - TX length registers place end of frame
// - Status bit 7 flags FIFO overflow
// - IRQ below 32 in TX, above 96 in RX
// - Transmission starts on first FIFO byte
// - Read indicator high during read data clocks
// - No FIFO access without slave select
// - Serial logic reset while select is high
// - Eight-bit words, MSB first both ways
module rhif_host_if (
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  input  wire logic       sclk_i,
  input  wire logic       ss_n_i,
  input  wire logic       mosi_i,
  input  wire logic [2:0] strap_i,
  input  wire logic       rx_active_i,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  output logic            miso_o,
  output logic            rd_ind_o,
  output logic            irq_o,
  output logic [7:0]      tx_data_o,
  output logic            tx_strobe_o,
  output logic            tx_eof_o,
  output logic [4:0]      cmd_code_o,
  output logic            cmd_strobe_o
);

  rhif_pkg::rhif_link_t lq;
  rhif_pkg::rhif_link_t ln;
  rhif_pkg::rhif_sys_t  q;
  rhif_pkg::rhif_sys_t  n;

  logic [7:0]  mem [0:126];
  logic [7:0]  full_byte;
  logic        evt;
  logic        link_on;
  logic        fifo_ok;
  logic        fifo_clr;
  logic        link_push;
  logic        link_pop;
  logic        push;
  logic        push_ok;
  logic        pop;
  logic        wr_en;
  logic [7:0]  push_data;
  logic [6:0]  rp_next;
  logic [12:0] tx_total;
  rhif_pkg::rhif_word_t w;

  function automatic logic [6:0] ptr_inc(input logic [6:0] p);
    ptr_inc = (p == rhif_pkg::FIFO_LAST) ? 7'h00 : p + 7'h01;
  endfunction

  function automatic rhif_pkg::rhif_ifmode_t strap_mode(
    input logic [2:0] s);
    if (s == rhif_pkg::STRAP_SPI_SS)
      strap_mode = rhif_pkg::IFM_SPI_SS;
    else if (s == rhif_pkg::STRAP_SPI_NOSS)
      strap_mode = rhif_pkg::IFM_SPI_NOSS;
    else
      strap_mode = rhif_pkg::IFM_PARALLEL;
  endfunction

  // Unmapped addresses read zero; the FIFO reads zero when empty
  function automatic logic [7:0] rd_value(input logic [4:0] a,
                                          input logic [6:0] rp,
                                          input logic       ok);
    rd_value = 8'h00;
    if (a == rhif_pkg::ADDR_FIFO_STATUS)
      rd_value = {q.ovf, q.count};
    else if (a == rhif_pkg::ADDR_TX_LEN_HIGH)
      rd_value = q.len_high;
    else if (a == rhif_pkg::ADDR_TX_LEN_LOW)
      rd_value = q.len_low;
    else if (a == rhif_pkg::ADDR_FIFO_DATA && ok && q.count != 7'h00)
      rd_value = mem[rp];
  endfunction

  // Link side: samples MOSI and shifts MISO on the falling data clock
  always_comb begin
    ln = lq;
    full_byte = {lq.in_sh, mosi_i};
    ln.in_sh = full_byte[6:0];
    ln.bit_cnt = lq.bit_cnt + 3'h1;
    if (lq.bit_cnt == 3'h0 && lq.phase == rhif_pkg::LP_DATA &&
        lq.reading) begin
      // Word prepared by the system side one clock earlier
      ln.miso = q.rd_word[7];
      ln.out_sh = q.rd_word[6:0];
    end else begin
      ln.miso = lq.out_sh[6];
      ln.out_sh = {lq.out_sh[5:0], 1'b0};
    end
    // Word-ready is a one-clock level, so a select reset only drops it
    // and never fakes a new word on the system side
    ln.req_tog = lq.bit_cnt == 3'h7;
    if (lq.bit_cnt == 3'h7) begin
      ln.req.data = full_byte;
      ln.req.is_ctrl = (lq.phase == rhif_pkg::LP_CTRL);
      if (lq.phase == rhif_pkg::LP_CTRL) begin
        ln.phase = rhif_pkg::LP_DATA;
        ln.reading = ~full_byte[rhif_pkg::CTRL_CMD_BIT] &
                     full_byte[rhif_pkg::CTRL_READ_BIT];
        ln.cont = full_byte[rhif_pkg::CTRL_CONT_BIT];
        ln.rd_ind = ln.reading;
      end else if (!lq.cont) begin
        ln.rd_ind = 1'b0;
        ln.reading = 1'b0;
      end
    end
  end

  // Slave select clears the link at once, even with the clock stopped
  always_ff @(negedge sclk_i or posedge ss_n_i) begin
    if (ss_n_i) begin
      lq <= '0;
    end else begin
      lq <= ln;
    end
  end

  assign miso_o = lq.miso;
  assign rd_ind_o = lq.rd_ind;
  assign w = lq.req;
  assign tx_total = {1'b0, q.len_high, q.len_low[7:4]} +
                    {12'h000, q.len_low[rhif_pkg::LEN_PART_BIT]};

  // System side
  always_comb begin
    n = q;
    fifo_clr = 1'b0;
    link_push = 1'b0;
    link_pop = 1'b0;
    wr_en = 1'b0;
    push = 1'b0;
    push_ok = 1'b0;
    pop = 1'b0;
    push_data = w.data;
    rp_next = q.rptr;
    n.strap_s1 = strap_i;
    n.strap_s2 = q.strap_s1;
    n.tog_s1 = lq.req_tog;
    n.tog_s2 = q.tog_s1;
    n.tog_seen = q.tog_s2;
    n.cmd_strobe = 1'b0;
    n.tx_strobe = 1'b0;
    n.tx_eof = 1'b0;
    if (!q.mode_valid) begin
      if (q.settle == rhif_pkg::STRAP_SETTLE) begin
        n.mode_valid = 1'b1;
        n.mode = strap_mode(q.strap_s2);
      end else begin
        n.settle = q.settle + 2'h1;
      end
    end
    // Parallel strap or unsampled straps leave the serial link ignored
    link_on = q.mode_valid && q.mode != rhif_pkg::IFM_PARALLEL;
    evt = q.tog_s2 && !q.tog_seen && link_on;
    fifo_ok = q.mode != rhif_pkg::IFM_SPI_NOSS;
    if (evt) begin
      if (w.is_ctrl) begin
        n.addr = w.data[4:0];
        n.data_seen = 1'b0;
        if (w.data[rhif_pkg::CTRL_CMD_BIT]) begin
          n.is_cmd = 1'b1;
          n.read_mode = 1'b0;
          n.cont = 1'b0;
          n.cmd_code = w.data[4:0];
          n.cmd_strobe = 1'b1;
          fifo_clr = w.data[4:0] == rhif_pkg::CMD_FIFO_RESET;
        end else begin
          n.is_cmd = 1'b0;
          n.read_mode = w.data[rhif_pkg::CTRL_READ_BIT];
          n.cont = w.data[rhif_pkg::CTRL_CONT_BIT];
          n.rd_word = rd_value(w.data[4:0], q.rptr, fifo_ok);
        end
      end else if (!q.is_cmd && (q.cont || !q.data_seen)) begin
        n.data_seen = 1'b1;
        // A stream that reaches the FIFO stays on it, so one frame can
        // carry the length bytes and a long FIFO load
        if (q.cont && q.addr != rhif_pkg::ADDR_FIFO_DATA)
          n.addr = q.addr + 5'h01;
        if (q.read_mode) begin
          // A FIFO byte is consumed only once it has been shifted out
          if (q.addr == rhif_pkg::ADDR_FIFO_DATA && fifo_ok &&
              q.count != 7'h00) begin
            link_pop = 1'b1;
            rp_next = ptr_inc(q.rptr);
          end
          if (q.cont)
            n.rd_word = rd_value(n.addr, rp_next,
                                 fifo_ok && !(link_pop && q.count == 7'h01));
        end else begin
          wr_en = 1'b1;
          if (q.addr == rhif_pkg::ADDR_TX_LEN_HIGH)
            n.len_high = w.data;
          else if (q.addr == rhif_pkg::ADDR_TX_LEN_LOW)
            n.len_low = w.data;
          else if (q.addr == rhif_pkg::ADDR_FIFO_DATA && fifo_ok)
            link_push = 1'b1;
        end
      end
    end
    // Receive bytes are dropped in cycles with a host FIFO write; one write port only
    push = link_push | (rx_active_i & rx_valid_i);
    if (!link_push)
      push_data = rx_data_i;
    push_ok = push && q.count != rhif_pkg::FIFO_FULL;
    if (push && !push_ok)
      n.ovf = 1'b1;
    if (link_push && push_ok && !q.tx_active && !rx_active_i &&
        tx_total != 13'h0000) begin
      n.tx_active = 1'b1;
      n.tx_sent = 13'h0000;
      n.tx_timer = 16'h0000;
    end
    pop = link_pop;
    if (q.tx_active && !link_pop && q.count != 7'h00) begin
      if (q.tx_timer == 16'h0000) begin
        pop = 1'b1;
        n.tx_data = mem[q.rptr];
        n.tx_strobe = 1'b1;
        n.tx_sent = q.tx_sent + 13'h0001;
        n.tx_timer = rhif_pkg::TX_RELOAD;
        if (q.tx_sent + 13'h0001 == tx_total) begin
          n.tx_eof = 1'b1;
          n.tx_active = 1'b0;
        end
      end else begin
        n.tx_timer = q.tx_timer - 16'h0001;
      end
    end
    if (push_ok)
      n.wptr = ptr_inc(q.wptr);
    if (pop)
      n.rptr = ptr_inc(q.rptr);
    if (push_ok && !pop)
      n.count = q.count + 7'h01;
    else if (pop && !push_ok)
      n.count = q.count - 7'h01;
    if (fifo_clr) begin
      n.count = 7'h00;
      n.wptr = 7'h00;
      n.rptr = 7'h00;
      n.ovf = 1'b0;
      n.tx_active = 1'b0;
    end
    n.irq = (q.tx_active && q.count < rhif_pkg::FIFO_LOW) ||
            (rx_active_i && q.count > rhif_pkg::FIFO_HIGH);
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push_ok && !fifo_clr) begin
      mem[q.wptr] <= push_data;
    end
  end

  assign irq_o = q.irq;
  assign tx_data_o = q.tx_data;
  assign tx_strobe_o = q.tx_strobe;
  assign tx_eof_o = q.tx_eof;
  assign cmd_code_o = q.cmd_code;
  assign cmd_strobe_o = q.cmd_strobe;

  a_irq_low_level: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    q.tx_active && q.count < rhif_pkg::FIFO_LOW |=> irq_o)
    else $error("irq missing while transmit FIFO runs low");

  a_irq_quiet: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    !q.tx_active && !rx_active_i |=> !irq_o)
    else $error("irq raised with no transfer running");

  a_ovf_set: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    push && !pop && q.count == rhif_pkg::FIFO_FULL && !fifo_clr
    |=> q.ovf && q.count == rhif_pkg::FIFO_FULL)
    else $error("overflow not flagged on full FIFO");

  a_fifo_reset: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    fifo_clr |=> q.count == 7'h00 && !q.ovf ##1 cmd_strobe_o == 1'b0)
    else $error("FIFO not emptied by reset command");

  a_count_bound: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    q.count <= rhif_pkg::FIFO_FULL)
    else $error("FIFO count beyond capacity");

  a_strap_hold: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    q.mode_valid |=> q.mode_valid && $stable(q.mode))
    else $error("interface mode changed after sampling");

  a_cmd_decode: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    evt && w.is_ctrl && w.data[7]
    |=> cmd_strobe_o && cmd_code_o == $past(w.data[4:0]))
    else $error("command word not decoded");

  a_single_word: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    evt && !w.is_ctrl && !q.cont && q.data_seen |-> !wr_en && !link_pop)
    else $error("extra word accepted in single mode");

  a_noss_fifo: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    q.mode == rhif_pkg::IFM_SPI_NOSS |-> !link_push && !link_pop)
    else $error("FIFO reached without slave select");

  a_cont_step: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    evt && !w.is_ctrl && !q.is_cmd && q.cont &&
    q.addr != rhif_pkg::ADDR_FIFO_DATA
    |=> q.addr == $past(q.addr) + 5'h01)
    else $error("continuous address did not advance");

  a_fifo_stay: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    evt && !w.is_ctrl && !q.is_cmd && q.cont &&
    q.addr == rhif_pkg::ADDR_FIFO_DATA
    |=> q.addr == rhif_pkg::ADDR_FIFO_DATA)
    else $error("continuous stream left the FIFO");

  a_par_idle: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    q.mode_valid && q.mode == rhif_pkg::IFM_PARALLEL
    |=> !cmd_strobe_o && $stable(q.len_high) && $stable(q.len_low))
    else $error("serial link active under parallel strap");

  a_tx_autostart: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    link_push && push_ok && !q.tx_active && !rx_active_i &&
    tx_total != 13'h0000 && !fifo_clr |=> q.tx_active ##1 tx_strobe_o)
    else $error("transmission did not start on first byte");

  a_rd_window: assert property (
    @(negedge sclk_i) disable iff (ss_n_i)
    lq.bit_cnt == 3'h7 && lq.phase == rhif_pkg::LP_CTRL &&
    !full_byte[7] && full_byte[6] |=> rd_ind_o [*8])
    else $error("read indicator not high for data clocks");

  c_cont_write: cover property (
    @(posedge mclk_i) disable iff (!nrst_i)
    evt && !w.is_ctrl && q.cont && !q.read_mode && q.data_seen);

  c_fifo_read: cover property (
    @(posedge mclk_i) disable iff (!nrst_i) link_pop);

  c_fifo_reset: cover property (
    @(posedge mclk_i) disable iff (!nrst_i) fifo_clr);

  c_tx_eof: cover property (
    @(posedge mclk_i) disable iff (!nrst_i) tx_eof_o);

endmodule

`default_nettype wire

// ### hdl/rhif_pkg.sv
package rhif_pkg;

  localparam logic [4:0] ADDR_FIFO_STATUS = 5'h1c;
  localparam logic [4:0] ADDR_TX_LEN_HIGH = 5'h1d;
  localparam logic [4:0] ADDR_TX_LEN_LOW  = 5'h1e;
  localparam logic [4:0] ADDR_FIFO_DATA   = 5'h1f;

  localparam int CTRL_CMD_BIT  = 7;
  localparam int CTRL_READ_BIT = 6;
  localparam int CTRL_CONT_BIT = 5;
  localparam int LEN_PART_BIT  = 0;

  localparam logic [4:0] CMD_FIFO_RESET = 5'h0f;

  localparam logic [6:0] FIFO_LAST  = 7'h7e;
  localparam logic [6:0] FIFO_FULL  = 7'h7f;
  localparam logic [6:0] FIFO_LOW   = 7'h20;
  localparam logic [6:0] FIFO_HIGH  = 7'h60;

  localparam logic [2:0] STRAP_SPI_SS   = 3'h6;
  localparam logic [2:0] STRAP_SPI_NOSS = 3'h4;
  localparam logic [1:0] STRAP_SETTLE   = 2'h3;

  localparam int CLK_PERIOD_NS = 10;
  localparam int TX_BYTE_NS    = 640;
  localparam int TX_BYTE_CYC   =
    (TX_BYTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] TX_RELOAD = 16'(TX_BYTE_CYC - 1);

  typedef enum logic [1:0] {
    IFM_PARALLEL = 2'b00,
    IFM_SPI_SS   = 2'b01,
    IFM_SPI_NOSS = 2'b10
  } rhif_ifmode_t;

  typedef enum logic {
    LP_CTRL = 1'b0,
    LP_DATA = 1'b1
  } rhif_lphase_t;

  typedef struct packed {
    logic [7:0] data;
    logic       is_ctrl;
  } rhif_word_t;

  typedef struct packed {
    rhif_lphase_t phase;
    logic [2:0]   bit_cnt;
    logic [6:0]   in_sh;
    logic [6:0]   out_sh;
    logic         miso;
    logic         reading;
    logic         cont;
    logic         rd_ind;
    logic         req_tog;
    rhif_word_t   req;
  } rhif_link_t;

  typedef struct packed {
    logic [2:0]   strap_s1;
    logic [2:0]   strap_s2;
    logic [1:0]   settle;
    logic         mode_valid;
    rhif_ifmode_t mode;
    logic         tog_s1;
    logic         tog_s2;
    logic         tog_seen;
    logic [4:0]   addr;
    logic         is_cmd;
    logic         read_mode;
    logic         cont;
    logic         data_seen;
    logic [7:0]   rd_word;
    logic [6:0]   count;
    logic [6:0]   wptr;
    logic [6:0]   rptr;
    logic         ovf;
    logic [7:0]   len_high;
    logic [7:0]   len_low;
    logic         tx_active;
    logic [12:0]  tx_sent;
    logic [15:0]  tx_timer;
    logic [7:0]   tx_data;
    logic         tx_strobe;
    logic         tx_eof;
    logic [4:0]   cmd_code;
    logic         cmd_strobe;
    logic         irq;
  } rhif_sys_t;

endpackage
